// *** design/erb_map.vh ***
`ifndef ERB_MAP_VH
`define ERB_MAP_VH

// register byte offsets on the avalon slave (one word each, low byte used)
`define ERB_OFS_IRQ_EN 7'h00
`define ERB_OFS_IRQ_FLG 7'h04
`define ERB_OFS_STATUS 7'h08
`define ERB_OFS_CTRL1 7'h0c
`define ERB_OFS_CTRL2 7'h10
`define ERB_OFS_RXST_L 7'h14
`define ERB_OFS_RXST_H 7'h18
`define ERB_OFS_RXND_L 7'h1c
`define ERB_OFS_RXND_H 7'h20
`define ERB_OFS_REL_L 7'h24
`define ERB_OFS_REL_H 7'h28
`define ERB_OFS_RDP_L 7'h2c
`define ERB_OFS_RDP_H 7'h30
`define ERB_OFS_BUF_DATA 7'h34
`define ERB_OFS_WRP_L 7'h38
`define ERB_OFS_WRP_H 7'h3c
`define ERB_OFS_PKT_CNT 7'h40
`define ERB_OFS_MXFL_L 7'h44
`define ERB_OFS_MXFL_H 7'h48

// field positions
`define ERB_BIT_PKT 6
`define ERB_BIT_RXERR 0
`define ERB_BIT_RECEIVE_ENABLE 2
`define ERB_BIT_AUTO_INCREMENT_ENABLE 7
`define ERB_BIT_PACKET_COUNT_DECREMENT 6
`define ERB_BIT_BUSY 2

// writable bits of the control style registers
`define ERB_MASK_IRQ_EN 8'h41
`define ERB_MASK_CTRL1 8'h04
`define ERB_MASK_CTRL2 8'h80

// reset values
`define ERB_RST_BYTE 8'h00
`define ERB_RST_RXST 13'h0000
`define ERB_RST_RXND 13'h1fff
`define ERB_RST_MXFL 16'h05ee
`define ERB_RST_STAT 32'h00000000

// counts
`define ERB_CNT_MAX 8'hff
`define ERB_CNT_ONE 8'h01
`define ERB_CNT_ZERO 8'h00
`define ERB_HDR_FIRST 3'h0
`define ERB_HDR_LAST 3'h5

`endif

// *** design/erb_avs_ack.v ***
`timescale 1ns/10ps
`default_nettype none

module erb_avs_ack (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // avalon request
    input wire read_in,
    input wire write_in,
    // handshake
    output reg wait_out,
    output wire load_out,
    output wire take_out
);

    wire req;

    assign req = read_in | write_in;
    // load read data while stalled, so it stands at the taking edge
    assign load_out = req & wait_out;
    assign take_out = req & ~wait_out;

    // one stall cycle per request; high again right after the take
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_out <= 1'b1;
        end else if (req && wait_out) begin
            wait_out <= 1'b0;
        end else begin
            wait_out <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// *** design/erb_ring_mem.v ***
`timescale 1ns/10ps
`default_nettype none

module erb_ring_mem #(
    parameter AW = 13,
    parameter DW = 8
) (
    // clock
    input wire clk_in,
    // write port
    input wire we_in,
    input wire [AW-1:0] waddr_in,
    input wire [DW-1:0] wdata_in,
    // read port
    input wire [AW-1:0] raddr_in,
    output wire [DW-1:0] rdata_out
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // asynchronous read so a moved read pointer is visible next cycle
    assign rdata_out = mem[raddr_in];

    // no reset: buffer content is undefined until written
    always @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

endmodule

`default_nettype wire

// *** design/erb_rx_ring.v ***
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "erb_map.vh"

// Notes on behaviour
// R01: with auto increment, buffer data reads advance read pointer, wrapping end to start
// R02: software wraps random access addresses itself before loading the read pointer
// R03: frame writes stop just short of the release pointer, never onto it
// R04: a frame hitting the release pointer aborts and sets the error flag
// R05: release pointer low byte write only fills a hidden holding byte
// R06: high byte write updates high and copies held low byte together
// R07: release pointer reads show live value; holding byte is never readable
// R08: software writes release pointer low byte first, then high byte
// R09: packet decrement command lowers pending count by one
// R10: after decrement, pending flag clears only when count reached zero
// R11: decrement at zero count leaves count at zero, no wrap
// R12: with receive enabled, count at maximum aborts every new frame and sets error flag
// R13: write pointer moves only when a whole good frame is stored or the rx start register is written
// R14: write pointer is thirteen bits, read as separate low and high bytes
// R15: write pointer never lands on release pointer; one byte stays unused
// R16: software rereads pointer bytes until pending count matches around them
// R17: software derives free space from write, release, start and end
// R18: software consumes frames strictly in arrival order
// R19: completed frame bumps count, sets pending flag, interrupt, moves pointer
// R20: odd next address gets one pad byte so frames start even
// R21: each frame is preceded by next pointer and status vector header
// R22: internal write address wraps from buffer end to buffer start

module erb_rx_ring #(
    parameter AW = 13
) (
    // clock and reset
    input wire ref_clk_in,
    input wire sys_rst_in,
    // avalon-mm register slave
    input wire [6:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // mac receive byte stream
    input wire rx_valid_in,
    input wire [7:0] rx_data_in,
    input wire rx_last_in,
    input wire rx_good_in,
    input wire [31:0] rx_status_in,
    output reg rx_ready_out,
    // interrupt request
    output reg eth_irq_out
);

    // writer states
    localparam ST_IDLE = 3'b000;
    localparam ST_SKIP = 3'b001;
    localparam ST_DATA = 3'b010;
    localparam ST_PAD = 3'b011;
    localparam ST_HDR = 3'b100;
    localparam ST_DROP = 3'b101;

    // software visible registers, plus the hidden release pointer holding byte
    reg [7:0] irq_en_reg;
    reg err_flag_reg;
    reg pkt_flag_reg;
    reg [7:0] ctrl1_reg;
    reg [7:0] ctrl2_reg;
    reg [AW-1:0] start_reg;
    reg [AW-1:0] end_reg;
    reg [AW-1:0] rel_reg;
    reg [7:0] rel_hold_reg;
    reg [AW-1:0] rdptr_reg;
    reg [AW-1:0] wrptr_reg;
    reg [7:0] cnt_reg;
    reg [15:0] mxfl_reg;

    // frame writer state
    reg [2:0] st_reg;
    reg [2:0] st_next;
    reg [2:0] k_reg;
    reg [2:0] k_next;
    reg [AW-1:0] addr_reg;
    reg [AW-1:0] addr_next;
    reg [AW-1:0] hdr_reg;
    reg [AW-1:0] hdr_next;
    reg [AW-1:0] nxt_reg;
    reg [AW-1:0] nxt_next;
    reg [31:0] stat_reg;
    reg [31:0] stat_next;

    // writer events and memory write port
    reg rx_abort;
    reg rx_commit;
    reg mem_we;
    reg [AW-1:0] mem_wa;
    reg [7:0] mem_wd;

    // bus side
    reg [7:0] rd_mux;
    wire bus_load;
    wire bus_take;
    wire wr_go;
    wire rd_go;
    wire dec_go;
    wire [7:0] wd;
    wire [AW-1:0] a_n;
    wire [7:0] buf_rdata;

    // next address in the ring, end wraps to start
    function [AW-1:0] wrap_inc;
        input [AW-1:0] a;
        begin
            if (a == end_reg) begin
                wrap_inc = start_reg;
            end else begin
                wrap_inc = a + {{(AW-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    // upper pointer bits shown in a byte lane
    function [7:0] hi8;
        input [AW-1:0] p;
        begin
            hi8 = {{(16-AW){1'b0}}, p[AW-1:8]};
        end
    endfunction

    // frame header: next pointer low, high, then status vector lsb first
    function [7:0] hdr_byte;
        input [2:0] k;
        begin
            case (k)
                3'h0: hdr_byte = nxt_reg[7:0];
                3'h1: hdr_byte = hi8(nxt_reg);
                3'h2: hdr_byte = stat_reg[7:0];
                3'h3: hdr_byte = stat_reg[15:8];
                3'h4: hdr_byte = stat_reg[23:16];
                default: hdr_byte = stat_reg[31:24];
            endcase
        end
    endfunction

    // bus strobes; a write needs the low byte lane, registers are 8 bit
    assign wd = avs_writedata_in[7:0];
    assign wr_go = bus_take & avs_write_in & avs_byteenable_in[0];
    assign rd_go = bus_take & avs_read_in;
    assign dec_go = wr_go && (avs_address_in == `ERB_OFS_CTRL2) &&
        wd[`ERB_BIT_PACKET_COUNT_DECREMENT]; // R09
    assign a_n = wrap_inc(addr_reg); // R22

    erb_avs_ack u_ack (
        .clk_in(ref_clk_in),
        .rst_in(sys_rst_in),
        .read_in(avs_read_in),
        .write_in(avs_write_in),
        .wait_out(avs_waitrequest_out),
        .load_out(bus_load),
        .take_out(bus_take)
    );

    erb_ring_mem #(
        .AW(AW),
        .DW(8)
    ) u_mem (
        .clk_in(ref_clk_in),
        .we_in(mem_we),
        .waddr_in(mem_wa),
        .wdata_in(mem_wd),
        .raddr_in(rdptr_reg),
        .rdata_out(buf_rdata)
    );

    // frame writer: reserve header, store data, pad, write header, commit
    always @* begin
        st_next = st_reg;
        k_next = k_reg;
        addr_next = addr_reg;
        hdr_next = hdr_reg;
        nxt_next = nxt_reg;
        stat_next = stat_reg;
        rx_abort = 1'b0;
        rx_commit = 1'b0;
        mem_we = 1'b0;
        mem_wa = addr_reg;
        mem_wd = rx_data_in;
        case (st_reg)
            ST_IDLE: begin
                if (rx_valid_in) begin
                    k_next = `ERB_HDR_FIRST;
                    addr_next = wrptr_reg;
                    hdr_next = wrptr_reg;
                    if (!ctrl1_reg[`ERB_BIT_RECEIVE_ENABLE]) begin
                        st_next = ST_DROP;
                    end else if (cnt_reg == `ERB_CNT_MAX) begin
                        rx_abort = 1'b1; // R12
                        st_next = ST_DROP; // R12
                    end else begin
                        st_next = ST_SKIP;
                    end
                end
            end
            ST_SKIP: begin
                // step over the header bytes, checked like data bytes
                if (a_n == rel_reg) begin
                    rx_abort = 1'b1; // R04
                    st_next = ST_DROP; // R03
                end else begin
                    addr_next = a_n;
                    k_next = k_reg + 3'h1;
                    if (k_reg == `ERB_HDR_LAST) begin
                        st_next = ST_DATA; // R21
                    end
                end
            end
            ST_DATA: begin
                if (rx_valid_in && rx_ready_out) begin
                    mem_we = 1'b1;
                    addr_next = a_n; // R22
                    if (a_n == rel_reg) begin
                        rx_abort = 1'b1; // R04
                        st_next = rx_last_in ? ST_IDLE : ST_DROP; // R03
                    end else if (rx_last_in) begin
                        stat_next = rx_status_in;
                        // bad frames vanish silently, pointer untouched
                        st_next = rx_good_in ? ST_PAD : ST_IDLE; // R13
                    end
                end
            end
            ST_PAD: begin
                k_next = `ERB_HDR_FIRST;
                st_next = ST_HDR;
                if (addr_reg[0]) begin
                    // pad byte keeps the next frame even aligned
                    if (a_n == rel_reg) begin
                        rx_abort = 1'b1; // R15
                        st_next = ST_IDLE; // R15
                    end else begin
                        nxt_next = a_n; // R20
                    end
                end else begin
                    nxt_next = addr_reg;
                end
            end
            ST_HDR: begin
                mem_we = 1'b1;
                mem_wa = hdr_reg;
                mem_wd = hdr_byte(k_reg); // R21
                hdr_next = wrap_inc(hdr_reg); // R22
                k_next = k_reg + 3'h1;
                if (k_reg == `ERB_HDR_LAST) begin
                    rx_commit = 1'b1; // R19
                    st_next = ST_IDLE;
                end
            end
            ST_DROP: begin
                if (rx_valid_in && rx_ready_out && rx_last_in) begin
                    st_next = ST_IDLE;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    // register read decode; unmapped offsets read as zero
    always @* begin
        rd_mux = `ERB_RST_BYTE;
        if (avs_address_in == `ERB_OFS_IRQ_EN) begin
            rd_mux = irq_en_reg;
        end else if (avs_address_in == `ERB_OFS_IRQ_FLG) begin
            rd_mux[`ERB_BIT_PKT] = pkt_flag_reg;
            rd_mux[`ERB_BIT_RXERR] = err_flag_reg;
        end else if (avs_address_in == `ERB_OFS_STATUS) begin
            rd_mux[`ERB_BIT_BUSY] = (st_reg != ST_IDLE);
        end else if (avs_address_in == `ERB_OFS_CTRL1) begin
            rd_mux = ctrl1_reg;
        end else if (avs_address_in == `ERB_OFS_CTRL2) begin
            rd_mux = ctrl2_reg; // decrement bit always reads zero
        end else if (avs_address_in == `ERB_OFS_RXST_L) begin
            rd_mux = start_reg[7:0];
        end else if (avs_address_in == `ERB_OFS_RXST_H) begin
            rd_mux = hi8(start_reg);
        end else if (avs_address_in == `ERB_OFS_RXND_L) begin
            rd_mux = end_reg[7:0];
        end else if (avs_address_in == `ERB_OFS_RXND_H) begin
            rd_mux = hi8(end_reg);
        end else if (avs_address_in == `ERB_OFS_REL_L) begin
            rd_mux = rel_reg[7:0]; // R07
        end else if (avs_address_in == `ERB_OFS_REL_H) begin
            rd_mux = hi8(rel_reg); // R07
        end else if (avs_address_in == `ERB_OFS_RDP_L) begin
            rd_mux = rdptr_reg[7:0];
        end else if (avs_address_in == `ERB_OFS_RDP_H) begin
            rd_mux = hi8(rdptr_reg);
        end else if (avs_address_in == `ERB_OFS_BUF_DATA) begin
            rd_mux = buf_rdata;
        end else if (avs_address_in == `ERB_OFS_WRP_L) begin
            rd_mux = wrptr_reg[7:0]; // R14
        end else if (avs_address_in == `ERB_OFS_WRP_H) begin
            rd_mux = hi8(wrptr_reg); // R14
        end else if (avs_address_in == `ERB_OFS_PKT_CNT) begin
            rd_mux = cnt_reg;
        end else if (avs_address_in == `ERB_OFS_MXFL_L) begin
            rd_mux = mxfl_reg[7:0];
        end else if (avs_address_in == `ERB_OFS_MXFL_H) begin
            rd_mux = mxfl_reg[15:8];
        end
    end

    // all state; later assignments in this block take priority
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            avs_readdata_out <= `ERB_RST_STAT;
            rx_ready_out <= 1'b0;
            eth_irq_out <= 1'b0;
            irq_en_reg <= `ERB_RST_BYTE;
            err_flag_reg <= 1'b0;
            pkt_flag_reg <= 1'b0;
            ctrl1_reg <= `ERB_RST_BYTE;
            ctrl2_reg <= `ERB_RST_BYTE;
            start_reg <= `ERB_RST_RXST;
            end_reg <= `ERB_RST_RXND;
            rel_reg <= `ERB_RST_RXST;
            rel_hold_reg <= `ERB_RST_BYTE;
            rdptr_reg <= `ERB_RST_RXST;
            wrptr_reg <= `ERB_RST_RXST;
            cnt_reg <= `ERB_CNT_ZERO;
            mxfl_reg <= `ERB_RST_MXFL;
            st_reg <= ST_IDLE;
            k_reg <= `ERB_HDR_FIRST;
            addr_reg <= `ERB_RST_RXST;
            hdr_reg <= `ERB_RST_RXST;
            nxt_reg <= `ERB_RST_RXST;
            stat_reg <= `ERB_RST_STAT;
        end else begin
            // writer registers
            st_reg <= st_next;
            k_reg <= k_next;
            addr_reg <= addr_next;
            hdr_reg <= hdr_next;
            nxt_reg <= nxt_next;
            stat_reg <= stat_next;
            // ready is a flop, so it follows the state being entered
            rx_ready_out <= (st_next == ST_DATA) || (st_next == ST_DROP);

            // read data is captured in the stall cycle
            if (bus_load) begin
                avs_readdata_out <= {24'h000000, rd_mux};
            end

            // one irq line, one cycle behind the flags
            eth_irq_out <= (pkt_flag_reg & irq_en_reg[`ERB_BIT_PKT]) |
                (err_flag_reg & irq_en_reg[`ERB_BIT_RXERR]); // R04

            // register writes
            if (wr_go) begin
                if (avs_address_in == `ERB_OFS_IRQ_EN) begin
                    irq_en_reg <= wd & `ERB_MASK_IRQ_EN;
                end else if (avs_address_in == `ERB_OFS_IRQ_FLG) begin
                    if (!wd[`ERB_BIT_RXERR]) begin
                        err_flag_reg <= 1'b0;
                    end
                end else if (avs_address_in == `ERB_OFS_CTRL1) begin
                    ctrl1_reg <= wd & `ERB_MASK_CTRL1;
                end else if (avs_address_in == `ERB_OFS_CTRL2) begin
                    ctrl2_reg <= wd & `ERB_MASK_CTRL2;
                end else if (avs_address_in == `ERB_OFS_RXST_L) begin
                    start_reg[7:0] <= wd;
                    wrptr_reg <= {start_reg[AW-1:8], wd};
                end else if (avs_address_in == `ERB_OFS_RXST_H) begin
                    start_reg[AW-1:8] <= wd[AW-9:0];
                    wrptr_reg <= {wd[AW-9:0], start_reg[7:0]};
                end else if (avs_address_in == `ERB_OFS_RXND_L) begin
                    end_reg[7:0] <= wd;
                end else if (avs_address_in == `ERB_OFS_RXND_H) begin
                    end_reg[AW-1:8] <= wd[AW-9:0];
                end else if (avs_address_in == `ERB_OFS_REL_L) begin
                    rel_hold_reg <= wd; // R05
                end else if (avs_address_in == `ERB_OFS_REL_H) begin
                    rel_reg <= {wd[AW-9:0], rel_hold_reg}; // R06
                end else if (avs_address_in == `ERB_OFS_RDP_L) begin
                    rdptr_reg[7:0] <= wd;
                end else if (avs_address_in == `ERB_OFS_RDP_H) begin
                    rdptr_reg[AW-1:8] <= wd[AW-9:0];
                end else if (avs_address_in == `ERB_OFS_MXFL_L) begin
                    mxfl_reg[7:0] <= wd;
                end else if (avs_address_in == `ERB_OFS_MXFL_H) begin
                    mxfl_reg[15:8] <= wd;
                end
            end

            // sequential buffer reads walk the ring
            if (rd_go && (avs_address_in == `ERB_OFS_BUF_DATA) &&
                ctrl2_reg[`ERB_BIT_AUTO_INCREMENT_ENABLE]) begin
                rdptr_reg <= wrap_inc(rdptr_reg); // R01
            end

            // pending count: commit and decrement together cancel out
            if (rx_commit && !dec_go) begin
                cnt_reg <= cnt_reg + `ERB_CNT_ONE; // R19
            end else if (dec_go && !rx_commit &&
                cnt_reg != `ERB_CNT_ZERO) begin
                cnt_reg <= cnt_reg - `ERB_CNT_ONE; // R11
            end

            // pending flag: a new frame wins over a clearing decrement
            if (rx_commit) begin
                pkt_flag_reg <= 1'b1; // R19
            end else if (dec_go && cnt_reg <= `ERB_CNT_ONE) begin
                pkt_flag_reg <= 1'b0; // R10
            end

            // abort wins over a software clear in the same cycle
            if (rx_abort) begin
                err_flag_reg <= 1'b1; // R04
            end

            // only a complete good frame, or a write to the rx start register, moves the write pointer
            if (rx_commit) begin
                wrptr_reg <= nxt_reg; // R13
            end
        end
    end

endmodule

`default_nettype wire

// *** design/erb_rx_ring_unused_guard.v ***
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** tb/erb_rx_ring_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

module erb_rx_ring_asserts #(
    parameter AW = 13
) (
    // clock and reset
    input wire ref_clk_in,
    input wire sys_rst_in,
    // register slave
    input wire [6:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    // mac stream
    input wire rx_valid_in,
    input wire [7:0] rx_data_in,
    input wire rx_last_in,
    input wire rx_good_in,
    input wire [31:0] rx_status_in,
    input wire rx_ready_out,
    // interrupt
    input wire eth_irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    // a request is any read or write held by the master
    wire req = avs_read_in | avs_write_in;
    wire last_taken = rx_valid_in & rx_ready_out & rx_last_in;

    // one stall cycle, then a single-cycle grant
    stall_once_a: assert property (req && avs_waitrequest_out |=>
        !avs_waitrequest_out) else $error("no grant after one stall");
    wait_pulse_a: assert property (!avs_waitrequest_out |=>
        avs_waitrequest_out) else $error("grant longer than one cycle");
    idle_wait_a: assert property (!req |-> avs_waitrequest_out)
        else $error("grant without a request");
    grant_req_a: assert property ($fell(avs_waitrequest_out) |->
        $past(req) && req) else $error("grant not caused by request");
    // read data only moves while a request is being served
    rdata_hold_a: assert property (!req |=> $stable(avs_readdata_out))
        else $error("read data moved while idle");
    rdata_upper_a: assert property (avs_readdata_out[31:8] == 24'h0)
        else $error("read data upper bits set");
    // ready drops right after every frame end and rises only with a byte offered
    ready_drop_a: assert property (last_taken |=> !rx_ready_out)
        else $error("ready stayed high after last byte");
    ready_cause_a: assert property ($rose(rx_ready_out) |-> rx_valid_in)
        else $error("ready rose with no byte offered");

    cover property (avs_read_in && !avs_waitrequest_out);
    cover property (avs_write_in && !avs_waitrequest_out);
    cover property (last_taken);
    cover property ($rose(eth_irq_out));
endmodule

bind erb_rx_ring erb_rx_ring_asserts #(.AW(AW)) u_chk (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
    .rx_last_in(rx_last_in), .rx_good_in(rx_good_in),
    .rx_status_in(rx_status_in), .rx_ready_out(rx_ready_out),
    .eth_irq_out(eth_irq_out)
);

`default_nettype wire

// *** tb/erb_rx_ring_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "erb_map.vh"

module erb_rx_ring_tb_top;
    logic clk, rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic rv = 1'b0, rl = 1'b0, rg = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] rdat = 8'h00;
    logic [31:0] wd = 32'h0, q;
    logic [7:0] hb [10] = '{8'h0a, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44,
        8'ha0, 8'ha1, 8'ha2, 8'ha3};
    wire [31:0] rdo;
    wire wt, rdy, irq;
    int n_errors = 0, n_compared = 0, i;

    erb_rx_ring uut (
        .ref_clk_in(clk), .sys_rst_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdo),
        .avs_waitrequest_out(wt), .rx_valid_in(rv), .rx_data_in(rdat),
        .rx_last_in(rl), .rx_good_in(rg), .rx_status_in(32'h44332211),
        .rx_ready_out(rdy), .eth_irq_out(irq)
    );

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task tally_and_finish;
        begin
            if (n_errors == 0 && n_compared > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask

    task give_up;
        begin
            n_errors++;
            tally_and_finish;
        end
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        begin
            n_compared++;
            if (s !== e) begin
                n_errors++;
                $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
            end
        end
    endtask

    // one avalon transfer; request held until waitrequest is seen low
    task bus(input logic r, input logic [6:0] a, input logic [7:0] d);
        int w;
        begin
            @(posedge clk);
            addr <= a;
            rd <= r;
            wr <= !r;
            wd <= {24'h0, d};
            w = 0;
            @(posedge clk);
            while (wt !== 1'b0) begin
                w++;
                if (w > 40) give_up;
                @(posedge clk);
            end
            q = rdo;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask

    task wreg(input logic [6:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask

    task rreg(input logic [6:0] a, input logic [31:0] e);
        begin
            bus(1'b1, a, 8'h00);
            chk(q, e);
        end
    endtask

    // frame of n bytes a0, a1, ...; commit lands 7 cycles after the end
    task frame(input int n, input logic g);
        int k, w;
        begin
            @(posedge clk);
            for (k = 0; k < n; k++) begin
                rv <= 1'b1;
                rdat <= 8'ha0 + k[7:0];
                rl <= (k == n - 1);
                rg <= g;
                w = 0;
                @(posedge clk);
                while (rdy !== 1'b1) begin
                    w++;
                    if (w > 40) give_up;
                    @(posedge clk);
                end
            end
            rv <= 1'b0;
            rl <= 1'b0;
            repeat (10) @(posedge clk);
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rreg(`ERB_OFS_RXND_L, 32'hff);
        rreg(`ERB_OFS_RXND_H, 32'h1f);
        rreg(`ERB_OFS_MXFL_H, 32'h05);
        rreg(7'h60, 32'h0);
        // release pointer moves only on the high byte write
        wreg(`ERB_OFS_REL_L, 8'h34);
        rreg(`ERB_OFS_REL_L, 32'h00);
        wreg(`ERB_OFS_REL_H, 8'h01);
        rreg(`ERB_OFS_REL_L, 32'h34);
        rreg(`ERB_OFS_REL_H, 32'h01);
        wreg(`ERB_OFS_IRQ_EN, 8'h41);
        // receiver still off: frame swallowed, no count and no error
        frame(1, 1'b1);
        rreg(`ERB_OFS_IRQ_FLG, 32'h00);
        wreg(`ERB_OFS_CTRL1, 8'h04);
        // good frames, an odd end gets a pad byte, a bad one is dropped
        frame(4, 1'b1);
        rreg(`ERB_OFS_WRP_L, 32'h0a);
        rreg(`ERB_OFS_PKT_CNT, 32'h01);
        rreg(`ERB_OFS_IRQ_FLG, 32'h40);
        chk({31'h0, irq}, 32'h1);
        frame(3, 1'b1);
        rreg(`ERB_OFS_WRP_L, 32'h14);
        frame(2, 1'b0);
        rreg(`ERB_OFS_WRP_L, 32'h14);
        rreg(`ERB_OFS_PKT_CNT, 32'h02);
        // sequential readback of the first frame, then the end wrap
        wreg(`ERB_OFS_CTRL2, 8'h80);
        wreg(`ERB_OFS_RDP_L, 8'h00);
        wreg(`ERB_OFS_RDP_H, 8'h00);
        for (i = 0; i < 10; i++) begin
            rreg(`ERB_OFS_BUF_DATA, {24'h0, hb[i]});
        end
        wreg(`ERB_OFS_RDP_L, 8'hff);
        wreg(`ERB_OFS_RDP_H, 8'h1f);
        bus(1'b1, `ERB_OFS_BUF_DATA, 8'h00);
        rreg(`ERB_OFS_BUF_DATA, 32'h0a);
        // random access: start 1ffc plus offset 6 folds back to 0002
        wreg(`ERB_OFS_RDP_L, 8'h02);
        wreg(`ERB_OFS_RDP_H, 8'h00);
        rreg(`ERB_OFS_BUF_DATA, 32'h11);
        // decrements down to zero and one beyond
        wreg(`ERB_OFS_CTRL2, 8'hc0);
        rreg(`ERB_OFS_PKT_CNT, 32'h01);
        rreg(`ERB_OFS_CTRL2, 32'h80);
        rreg(`ERB_OFS_IRQ_FLG, 32'h40);
        wreg(`ERB_OFS_CTRL2, 8'hc0);
        rreg(`ERB_OFS_IRQ_FLG, 32'h00);
        wreg(`ERB_OFS_CTRL2, 8'hc0);
        rreg(`ERB_OFS_PKT_CNT, 32'h00);
        chk({31'h0, irq}, 32'h0);
        // a frame ending exactly on the release pointer is refused
        wreg(`ERB_OFS_REL_L, 8'h20);
        wreg(`ERB_OFS_REL_H, 8'h00);
        frame(6, 1'b1);
        rreg(`ERB_OFS_IRQ_FLG, 32'h01);
        rreg(`ERB_OFS_WRP_L, 32'h14);
        chk({31'h0, irq}, 32'h1);
        wreg(`ERB_OFS_IRQ_FLG, 8'h00);
        frame(4, 1'b1);
        rreg(`ERB_OFS_WRP_L, 32'h1e);
        chk(32'h20 - q - 32'h1, 32'h1);
        // fill the pending count to its ceiling
        wreg(`ERB_OFS_REL_L, 8'h10);
        wreg(`ERB_OFS_REL_H, 8'h00);
        for (i = 0; i < 254; i++) begin
            frame(1, 1'b1);
        end
        rreg(`ERB_OFS_PKT_CNT, 32'hff);
        rreg(`ERB_OFS_WRP_L, 32'h0e);
        rreg(`ERB_OFS_WRP_H, 32'h08);
        frame(1, 1'b1);
        rreg(`ERB_OFS_PKT_CNT, 32'hff);
        rreg(`ERB_OFS_IRQ_FLG, 32'h41);
        wreg(`ERB_OFS_CTRL2, 8'hc0);
        rreg(`ERB_OFS_PKT_CNT, 32'hfe);
        tally_and_finish;
    end
endmodule

`default_nettype wire
